// ---- dwd_device.sv ----
// Generator end: deserialiser, word decoder, register bank, phase
// accumulator and output selection.
// Assumes link pins change only after a system clock edge.
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ns
module dwd_device (
    // Clock and reset.
    input wire logic I_CLK_SYS,
    input wire logic I_SRST,
    // Serial link.
    dwd_link_if.dev LINK,
    // Generator outputs.
    output logic [9:0] O_WAVE_OUTPUT_PIN,
    output logic O_CONVERTER_POWERDOWN,
    output logic [15:0] O_CONTROL_WORD,
    output logic O_WORD_STROBE
);

    // ****************************************************************
    // Link receiver.
    // ****************************************************************
    logic sclk_q;
    logic sclk_fall;
    logic [15:0] rx_shift;
    logic [4:0] rx_count;
    logic [15:0] rx_word;
    logic word_valid;

    // Previous link clock level, kept for edge detection.
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            sclk_q <= 1'b1;
        end else begin
            sclk_q <= LINK.sclk;
        end
    end

    assign sclk_fall = sclk_q & ~LINK.sclk & ~LINK.fsync_n;

    // Bits enter MSB first; a frame that ends early is thrown away.
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            rx_shift <= '0;
            rx_count <= '0;
            rx_word <= '0;
            word_valid <= 1'b0;
        end else begin
            word_valid <= 1'b0;
            if (LINK.fsync_n) begin
                rx_count <= '0;
            end else if (sclk_fall) begin
                rx_shift <= {rx_shift[14:0], LINK.serial_data_in}; // see R20
                if (rx_count == dwd_pkg::LAST_BIT) begin
                    // Whole word captured at once, so no half word is seen.
                    rx_word <= {rx_shift[14:0], LINK.serial_data_in}; // see R21
                    word_valid <= 1'b1; // see R20
                    rx_count <= '0;
                end else begin
                    rx_count <= rx_count + 5'h01;
                end
            end
        end
    end

    // ****************************************************************
    // Word decoder.
    // ****************************************************************
    logic [1:0] dst;
    logic [13:0] payload;
    logic freq_write;
    logic freq_index;

    assign dst = rx_word[dwd_pkg::ADDR_HI:dwd_pkg::ADDR_LO];
    assign payload = rx_word[dwd_pkg::HALF_W-1:0];
    assign freq_write = word_valid & ((dst == dwd_pkg::DWD_DST_FREQ_A)
        | (dst == dwd_pkg::DWD_DST_FREQ_B)); // see R11
    assign freq_index = (dst == dwd_pkg::DWD_DST_FREQ_B);

    // ****************************************************************
    // Control register.
    // ****************************************************************
    logic [15:0] control_word_reg;
    logic full_width_load;
    logic half_select;
    logic freq_select;
    logic phase_select;
    logic converter_powerdown;
    logic square_output_enable;
    logic square_no_halve;
    logic triangle_mode;

    // Reserved bits are stored as sent; they steer nothing.
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            control_word_reg <= dwd_pkg::CONTROL_RESET;
        end else if (word_valid && dst == dwd_pkg::DWD_DST_CTRL) begin
            control_word_reg <= {dwd_pkg::DWD_DST_CTRL, payload}; // see R1
        end
    end

    assign full_width_load = control_word_reg[dwd_pkg::FULL_WIDTH_LOAD_POS];
    assign half_select = control_word_reg[dwd_pkg::HALF_SELECT_POS];
    assign freq_select = control_word_reg[dwd_pkg::FREQ_SELECT_POS]; // see R19
    assign phase_select = control_word_reg[dwd_pkg::PHASE_SELECT_POS]; // see R19
    assign converter_powerdown = control_word_reg[dwd_pkg::POWERDOWN_POS];
    assign square_output_enable = control_word_reg[dwd_pkg::SQUARE_ENABLE_POS];
    assign square_no_halve = control_word_reg[dwd_pkg::SQUARE_NO_HALVE_POS];
    assign triangle_mode = control_word_reg[dwd_pkg::TRIANGLE_MODE_POS];

    // ****************************************************************
    // Tuning registers.
    // ****************************************************************
    logic [27:0] freq_tuning [0:1];
    logic [13:0] low_hold;
    logic pend;
    logic pend_index;

    // Full-width pairs wait in a holding register; any other word cancels
    // the pair, and a write to the other register restarts it with a new low half.
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            freq_tuning[0] <= '0;
            freq_tuning[1] <= '0;
            low_hold <= '0;
            pend <= 1'b0;
            pend_index <= 1'b0;
        end else if (freq_write) begin
            if (full_width_load) begin
                if (pend && pend_index == freq_index) begin
                    freq_tuning[freq_index] <= {payload, low_hold}; // see R14, R16
                    pend <= 1'b0;
                end else begin
                    low_hold <= payload; // see R14
                    pend <= 1'b1;
                    pend_index <= freq_index;
                end
            end else if (half_select) begin
                freq_tuning[freq_index][dwd_pkg::ACC_W-1:dwd_pkg::HALF_W] <= payload; // see R15, R17
                pend <= 1'b0;
            end else begin
                freq_tuning[freq_index][dwd_pkg::HALF_W-1:0] <= payload; // see R15, R17
                pend <= 1'b0;
            end
        end else if (word_valid) begin
            pend <= 1'b0;
        end
    end

    // ****************************************************************
    // Phase offset registers.
    // ****************************************************************
    logic [11:0] phase_offset [0:1];

    // Bit 12 of a phase word carries nothing.
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            phase_offset[0] <= '0;
            phase_offset[1] <= '0;
        end else if (word_valid && dst == dwd_pkg::DWD_DST_PHASE) begin
            phase_offset[rx_word[dwd_pkg::PHASE_SEL_POS]] <=
                rx_word[dwd_pkg::PHASE_W-1:0]; // see R18
        end
    end

    // ****************************************************************
    // Phase accumulator.
    // ****************************************************************
    logic [27:0] selected_tuning_value;
    logic [11:0] selected_phase_value;
    logic [27:0] phase_acc;
    logic [11:0] phase_word;

    assign selected_tuning_value = freq_tuning[freq_select]; // see R12
    assign selected_phase_value = phase_offset[phase_select]; // see R13

    // Wraps modulo two to the 28, giving f = fclk * value / 2^28.
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            phase_acc <= '0;
        end else begin
            phase_acc <= phase_acc + selected_tuning_value; // see R9
        end
    end

    // Only the top bits of the accumulator address the waveform.
    assign phase_word = phase_acc[dwd_pkg::ACC_W-1:dwd_pkg::ACC_W-dwd_pkg::PHASE_W]
        + selected_phase_value; // see R10

    // ****************************************************************
    // Waveform shaping.
    // ****************************************************************
    // Parabolic stand-in for a sine table: it costs one multiplier and
    // no storage, at the price of a few percent of harmonic error.
    function automatic logic [9:0] sine_lookup_table(input logic [11:0] ph);
        logic [11:0] x;
        logic [23:0] prod;
        logic [9:0] amp;
        x = {1'b0, ph[10:0]};
        prod = 24'(x) * 24'(dwd_pkg::HALF_TURN - x);
        amp = (prod[20:11] > dwd_pkg::AMP_MAX) ? dwd_pkg::AMP_MAX : prod[20:11];
        sine_lookup_table = ph[11] ? dwd_pkg::DAC_MID - amp : dwd_pkg::DAC_MID + amp;
    endfunction

    logic [9:0] dac_code;
    logic dac_msb;
    logic dac_msb_q;
    logic halved_bit;
    logic square_bit;

    always_comb begin
        if (triangle_mode) begin
            // Folded ramp: rises over the first half turn, falls after.
            dac_code = phase_word[11] ? ~phase_word[10:1] : phase_word[10:1]; // see R6
        end else begin
            dac_code = sine_lookup_table(phase_word); // see R6
        end
    end

    assign dac_msb = dac_code[dwd_pkg::DAC_W-1];

    // The halved square toggles on each rising edge of the MSB.
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            dac_msb_q <= 1'b0;
            halved_bit <= 1'b0;
        end else begin
            dac_msb_q <= dac_msb;
            if (dac_msb && !dac_msb_q) begin
                halved_bit <= ~halved_bit; // see R5
            end
        end
    end

    assign square_bit = square_no_halve ? dac_msb : halved_bit; // see R5

    // ****************************************************************
    // Output pin.
    // ****************************************************************
    // With square enabled the converter is cut off and the pin swings
    // full scale; the host is expected to keep triangle mode off then.
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            O_WAVE_OUTPUT_PIN <= dwd_pkg::DAC_MID;
            O_CONVERTER_POWERDOWN <= 1'b0;
            O_CONTROL_WORD <= dwd_pkg::CONTROL_RESET;
            O_WORD_STROBE <= 1'b0;
        end else begin
            if (square_output_enable) begin
                O_WAVE_OUTPUT_PIN <= {dwd_pkg::DAC_W{square_bit}}; // see R3, R7
            end else begin
                O_WAVE_OUTPUT_PIN <= dac_code; // see R4
            end
            O_CONVERTER_POWERDOWN <= converter_powerdown; // see R2
            O_CONTROL_WORD <= control_word_reg;
            O_WORD_STROBE <= word_valid;
        end
    end

endmodule

// ---- dwd_pkg.sv ----
// Constants shared by both ends of the waveform-word link: word layout,
// control field positions, host register map and output coding.
// Assumes a single system clock on both ends; no other files are needed.
// ****************************************************************
// Functional notes
// R1 - Top bits 00 means control word update
// R2 - Control bit 6 powers down the converter
// R3 - Square enable drives pin with MSB/halved
// R4 - Square off: converter drives pin, sine/ramp
// R5 - Bit 3 one: MSB direct; zero: halved
// R6 - Bit 1 one: triangle; zero: sine table
// R7 - Host keeps mode zero with square enabled
// R8 - Host writes zero to bits 4, 2, 0
// R9 - Accumulator adds selected tuning value each clock
// R10 - Selected phase offset added to accumulator
// R11 - Top bits 01/10 load tuning a/b
// R12 - Tuning registers 28 bits, freq select picks
// R13 - Phase registers 12 bits, phase select picks
// R14 - Full-width: two writes, low then high
// R15 - Half mode: half select picks half replaced
// R16 - Full-width commit only after both halves
// R17 - Half select one high, zero low
// R18 - Top bits 11: bit 13 picks phase register
// R19 - Freq select bit 11, phase select bit 10
// R20 - Word applied after sixteen bits, MSB first
// R21 - Link words enter clock domain safely
// ****************************************************************
package dwd_pkg;

    // ****************************************************************
    // Serial word layout.
    // ****************************************************************
    localparam int WORD_W = 16;
    localparam int ADDR_HI = 15;
    localparam int ADDR_LO = 14;
    localparam int HALF_W = 14;
    localparam int ACC_W = 28;
    localparam int PHASE_W = 12;
    localparam int DAC_W = 10;
    localparam int PHASE_SEL_POS = 13;
    localparam logic [4:0] LAST_BIT = 5'h0F;
    localparam logic [4:0] WORD_BITS = 5'h10;

    // Destination codes held in the two top bits of a word.
    typedef enum logic [1:0] {
        DWD_DST_CTRL = 2'b00,
        DWD_DST_FREQ_A = 2'b01,
        DWD_DST_FREQ_B = 2'b10,
        DWD_DST_PHASE = 2'b11
    } dwd_dst_t;

    // ****************************************************************
    // Control word field positions.
    // ****************************************************************
    localparam int FULL_WIDTH_LOAD_POS = 13;
    localparam int HALF_SELECT_POS = 12;
    localparam int FREQ_SELECT_POS = 11;
    localparam int PHASE_SELECT_POS = 10;
    localparam int POWERDOWN_POS = 6;
    localparam int SQUARE_ENABLE_POS = 5;
    localparam int SQUARE_NO_HALVE_POS = 3;
    localparam int TRIANGLE_MODE_POS = 1;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;

    // ****************************************************************
    // Converter coding.
    // ****************************************************************
    localparam logic [9:0] DAC_MID = 10'h200;
    localparam logic [9:0] AMP_MAX = 10'h1FF;
    localparam logic [11:0] HALF_TURN = 12'h800;

    // ****************************************************************
    // Host register map (byte offsets) and reset values.
    // ****************************************************************
    localparam logic [7:0] REG_TX_WORD = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_CLK_DIV = 8'h08;
    localparam int CLK_DIV_W = 8;
    localparam logic [7:0] CLK_DIV_RESET = 8'h04;

endpackage

// ---- dwd_link_if.sv ----
// Three-wire serial link between the host controller and the generator.
// Assumes both ends run on the same system clock; no tri-state wires.
`timescale 1ns/1ns
interface dwd_link_if;
    logic sclk;
    logic fsync_n;
    logic serial_data_in;

    // The host makes the clock, the frame and the data.
    modport host (
        output sclk,
        output fsync_n,
        output serial_data_in
    );

    // The generator only listens.
    modport dev (
        input sclk,
        input fsync_n,
        input serial_data_in
    );
endinterface

// ---- dwd_host.sv ----
// Host end: APB slave registers and a serialiser that sends 16-bit
// words over the three-wire link, MSB first.
// Assumes an APB master on the same clock and a generator on the link.
`timescale 1ns/1ns
module dwd_host #(
    parameter logic [7:0] CLK_DIV_DEFAULT = dwd_pkg::CLK_DIV_RESET
) (
    // Clock and reset.
    input wire logic I_CLK_SYS,
    input wire logic I_SRST,
    // APB slave.
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [7:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    // Serial link.
    dwd_link_if.host LINK
);

    if (CLK_DIV_DEFAULT == 8'h00) begin : g_bad_div
        $error("CLK_DIV_DEFAULT must be at least one");
    end

    typedef enum logic [0:0] {
        DWD_ST_IDLE = 1'b0,
        DWD_ST_SHIFT = 1'b1
    } dwd_state_t;

    dwd_state_t state;
    logic [7:0] clk_div;
    logic [7:0] div_cnt;
    logic tick;
    logic [15:0] tx_word;
    logic [15:0] tx_shift;
    logic [4:0] bit_cnt;
    logic [15:0] frames_sent;
    logic busy;
    logic tx_sel;
    logic start;
    logic mapped;

    assign busy = (state != DWD_ST_IDLE);
    assign tx_sel = I_PSEL && I_PWRITE && I_PADDR == dwd_pkg::REG_TX_WORD;
    assign start = tx_sel && I_PENABLE && !busy;
    assign mapped = I_PADDR == dwd_pkg::REG_TX_WORD || I_PADDR == dwd_pkg::REG_STATUS
        || I_PADDR == dwd_pkg::REG_CLK_DIV;

    // ****************************************************************
    // APB registers.
    // ****************************************************************
    // A word write waits in the access phase while a frame is going out,
    // which stalls software rather than losing a word.
    assign O_PREADY = !(tx_sel && busy);
    assign O_PSLVERR = I_PSEL && I_PENABLE && !mapped;

    // Read data is captured in the setup cycle.
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            O_PRDATA <= '0;
        end else if (I_PSEL && !I_PENABLE) begin
            case (I_PADDR)
                dwd_pkg::REG_TX_WORD: O_PRDATA <= {16'h0000, tx_word};
                dwd_pkg::REG_STATUS: O_PRDATA <= {frames_sent, 15'h0000, busy};
                dwd_pkg::REG_CLK_DIV: O_PRDATA <= {24'h000000, clk_div};
                default: O_PRDATA <= '0;
            endcase
        end
    end

    // Divider register; a written zero is stored as one, so it reads back as one.
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            clk_div <= CLK_DIV_DEFAULT;
        end else if (I_PSEL && I_PENABLE && I_PWRITE && I_PADDR == dwd_pkg::REG_CLK_DIV) begin
            clk_div <= (I_PWDATA[7:0] == 8'h00) ? 8'h01 : I_PWDATA[7:0];
        end
    end

    // ****************************************************************
    // Link clock divider.
    // ****************************************************************
    // One tick per half period of the link clock.
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST || !busy) begin
            div_cnt <= 8'h01;
        end else if (div_cnt >= clk_div) begin
            div_cnt <= 8'h01;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    assign tick = busy && div_cnt >= clk_div;

    // ****************************************************************
    // Serialiser.
    // ****************************************************************
    // Data changes with the rising link clock and is stable at the fall,
    // where the generator samples it.
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            state <= DWD_ST_IDLE;
            LINK.sclk <= 1'b1;
            LINK.fsync_n <= 1'b1;
            LINK.serial_data_in <= 1'b0;
            tx_word <= '0;
            tx_shift <= '0;
            bit_cnt <= '0;
            frames_sent <= '0;
        end else begin
            case (state)
                DWD_ST_IDLE: begin
                    if (start) begin
                        // Bits 4, 2 and 0 of control words are up to software.
                        tx_word <= I_PWDATA[15:0]; // see R8
                        tx_shift <= I_PWDATA[15:0];
                        LINK.serial_data_in <= I_PWDATA[15]; // see R20
                        LINK.fsync_n <= 1'b0;
                        bit_cnt <= '0;
                        state <= DWD_ST_SHIFT;
                    end
                end
                DWD_ST_SHIFT: begin
                    if (tick) begin
                        if (LINK.sclk) begin
                            LINK.sclk <= 1'b0;
                            bit_cnt <= bit_cnt + 5'h01;
                        end else if (bit_cnt == dwd_pkg::WORD_BITS) begin
                            LINK.sclk <= 1'b1;
                            LINK.fsync_n <= 1'b1;
                            frames_sent <= frames_sent + 16'h0001;
                            state <= DWD_ST_IDLE;
                        end else begin
                            LINK.sclk <= 1'b1;
                            LINK.serial_data_in <= tx_shift[14];
                            tx_shift <= {tx_shift[14:0], 1'b0};
                        end
                    end
                end
                default: begin
                    state <= DWD_ST_IDLE;
                end
            endcase
        end
    end

endmodule

// ---- dwd_chk.sv ----
// Checker on the link wires and the generator outputs.
// Assumes one system clock and a synchronous active-high reset.
`timescale 1ns/1ns
module dwd_chk (
    // Clock and reset.
    input wire logic I_CLK_SYS,
    input wire logic I_SRST,
    // Link wires.
    input wire logic sclk,
    input wire logic fsync_n,
    input wire logic serial_data_in,
    // Generator outputs.
    input wire logic [9:0] O_WAVE_OUTPUT_PIN,
    input wire logic O_CONVERTER_POWERDOWN,
    input wire logic [15:0] O_CONTROL_WORD,
    input wire logic O_WORD_STROBE
);
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_SRST);
    logic sclk_q;
    logic [4:0] bit_cnt;
    logic [15:0] rx_word;

    // Rebuild each word from the wire, so decoded outputs can be tied to it.
    always_ff @(posedge I_CLK_SYS) begin
        sclk_q <= sclk;
        if (fsync_n) begin
            bit_cnt <= 5'h00;
        end else if (sclk_q && !sclk) begin
            bit_cnt <= bit_cnt + 5'h01;
            rx_word <= {rx_word[14:0], serial_data_in};
        end
    end

    sequence frame_end;
        $rose(fsync_n);
    endsequence
    sequence square_held;
        O_CONTROL_WORD[5] [*3];
    endsequence

    a_idle_clock_high: assert property (fsync_n |-> sclk)
        else $error("link clock low outside a frame");
    a_data_held_low: assert property (!sclk && !fsync_n |-> $stable(serial_data_in))
        else $error("serial data moved while the link clock was low");
    a_sixteen_bits: assert property (frame_end |-> bit_cnt == 5'h10)
        else $error("frame did not carry sixteen bits");
    a_strobe_follows: assert property (frame_end |-> ##[0:8] O_WORD_STROBE)
        else $error("word not applied after its frame");
    a_strobe_single: assert property (O_WORD_STROBE |=> !O_WORD_STROBE)
        else $error("word strobe longer than one cycle");
    a_ctrl_word_load: assert property (O_WORD_STROBE && rx_word[15:14] == 2'b00
        |=> O_CONTROL_WORD == rx_word)
        else $error("control word differs from the received word");
    a_ctrl_only_ctrl: assert property ($changed(O_CONTROL_WORD)
        |-> $past(O_WORD_STROBE) && rx_word[15:14] == 2'b00)
        else $error("control register moved without a control word");
    a_powerdown_bit: assert property (O_WORD_STROBE && rx_word[15:14] == 2'b00
        |=> O_CONVERTER_POWERDOWN == rx_word[6])
        else $error("power-down output differs from its control bit");
    a_square_levels: assert property (square_held
        |-> O_WAVE_OUTPUT_PIN == 10'h000 || O_WAVE_OUTPUT_PIN == 10'h3FF)
        else $error("square output not at a full level");
    a_reset_mid: assert property ($fell(I_SRST) |-> O_WAVE_OUTPUT_PIN == 10'h200)
        else $error("output not at midscale after reset");
endmodule

// ---- dds_word_decoder_regs_tb.sv ----
// Self-checking bench: APB drives the host end, which feeds the generator.
// Assumes the package, interface, both ends and the checker compile first.
`timescale 1ns/1ns
module dds_word_decoder_regs_tb;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [9:0] pin;
    logic pdown;
    logic [15:0] ctrl;
    logic strobe;
    logic [15:0] exp_q[$];
    logic [15:0] cur_ctrl = 16'h0000;
    logic strobe_q = 1'b0;
    int fail_count = 0;
    int n_compared = 0;
    int seed = 32'h191CDC86;

    // The clock runs at 100 MHz.
    always #5 clk = ~clk;

    dwd_link_if dwd_link_if_inst ();
    // A short divider of two at reset; the bench writes one before any word, so each frame is near thirty-two cycles.
    dwd_host #(.CLK_DIV_DEFAULT(8'h02)) dwd_host_inst (.I_CLK_SYS(clk), .I_SRST(srst),
        .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
        .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .LINK(dwd_link_if_inst));
    dwd_device dwd_device_inst (.I_CLK_SYS(clk), .I_SRST(srst), .LINK(dwd_link_if_inst),
        .O_WAVE_OUTPUT_PIN(pin), .O_CONVERTER_POWERDOWN(pdown), .O_CONTROL_WORD(ctrl),
        .O_WORD_STROBE(strobe));
    dwd_chk dwd_chk_inst (.I_CLK_SYS(clk), .I_SRST(srst), .sclk(dwd_link_if_inst.sclk),
        .fsync_n(dwd_link_if_inst.fsync_n), .serial_data_in(dwd_link_if_inst.serial_data_in),
        .O_WAVE_OUTPUT_PIN(pin), .O_CONVERTER_POWERDOWN(pdown), .O_CONTROL_WORD(ctrl),
        .O_WORD_STROBE(strobe));

    // ********
    // Shared tasks.
    // ********
    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        n_compared++;
        if (seen !== expv) begin
            fail_count++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask

    task automatic finish_test();
        $display("Mismatches %0d, comparisons %0d", fail_count, n_compared);
        if (fail_count == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // One APB transfer; the request holds until pready is seen at an edge.
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data,
        output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Data words leave the control word as it was, so it is noted again.
    task automatic send(input logic [15:0] w);
        logic [31:0] rd;
        logic err;
        if (w[15:14] == 2'b00) cur_ctrl = w;
        exp_q.push_back(cur_ctrl);
        apb(1'b1, dwd_pkg::REG_TX_WORD, {16'h0000, w}, rd, err);
    endtask

    task automatic applied();
        for (int i = 0; i < 400 && exp_q.size() > 0; i++) @(posedge clk);
        repeat (4) @(posedge clk);
    endtask

    task automatic rise();
        logic prev;
        prev = pin[9];
        repeat (2000) begin
            @(posedge clk);
            if (pin[9] === 1'b1 && prev === 1'b0) return;
            prev = pin[9];
        end
    endtask

    // A missing edge runs out the wait and shows as a wrong period.
    task automatic period(input int expv);
        time t0;
        rise();
        t0 = $time;
        rise();
        check(32'(($time - t0) / 10), 32'(expv));
    endtask

    task automatic still();
        logic [9:0] first;
        int changes;
        first = pin;
        changes = 0;
        repeat (150) begin
            @(posedge clk);
            if (pin !== first) changes++;
        end
        check(32'(changes), 32'h00000000);
    endtask

    // Each applied word is judged against the oldest noted control word.
    // The control output settles one cycle after the strobe, so look then.
    always @(posedge clk) begin
        strobe_q <= strobe;
        if (strobe_q === 1'b1) begin
            if (exp_q.size() == 0) begin
                check({16'h0000, ctrl}, 32'hFFFFFFFF);
            end else begin
                check({16'h0000, ctrl}, {16'h0000, exp_q.pop_front()});
            end
        end
    end

    initial begin
        logic [31:0] rd;
        logic err;
        logic [15:0] w;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        // Register reset value, refused address and read-back.
        apb(1'b0, dwd_pkg::REG_CLK_DIV, 32'h00000000, rd, err);
        check(rd, 32'h00000002);
        apb(1'b0, 8'h0C, 32'h00000000, rd, err);
        check({31'h00000000, err}, 32'h00000001);
        apb(1'b1, dwd_pkg::REG_CLK_DIV, 32'h00000001, rd, err);
        apb(1'b0, dwd_pkg::REG_CLK_DIV, 32'h00000000, rd, err);
        check(rd, 32'h00000001);
        // Random control words with reserved bits clear.
        for (int i = 0; i < 6; i++) begin
            w = 16'($random(seed)) & 16'h3C6A;
            if (w[5]) w[1] = 1'b0;
            send(w);
        end
        send(16'hC800);
        send(16'hE123);
        // Full width: a lone low half must not move the output.
        send(16'h2028);
        send(16'h4000);
        applied();
        still();
        send(16'h4100);
        applied();
        period(64);
        send(16'h2020);
        applied();
        period(128);
        // Half mode writes the high half of tuning b, then selects it.
        send(16'h1028);
        send(16'h8080);
        applied();
        period(64);
        send(16'h1828);
        applied();
        period(128);
        apb(1'b0, dwd_pkg::REG_STATUS, 32'h00000000, rd, err);
        check(rd & 32'h00000001, 32'h00000000);
        finish_test();
    end

    // Watchdog: the run needs well under ten thousand cycles.
    initial begin
        #200000;
        fail_count++;
        $display("ERROR %0t: watchdog expired", $time);
        finish_test();
    end
endmodule
